/* bench/probe_link_monitor.sv */
// Link checks for the unpowered-port probe handshake
`timescale 1ns/10ps
module probe_link_monitor #(
    parameter int PROBE_ON = 700,
    parameter int PROBE_INTERVAL = 50
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic probe_supply,
    input wire logic full_bus_voltage,
    input wire logic pattern_bit,
    input wire logic pattern_en_n
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [15:0] on_reg;
    logic [15:0] idle_reg;
    logic [15:0] flips_reg;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) on_reg <= 16'h0000;
        else on_reg <= probe_supply ? on_reg + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) idle_reg <= 16'h0000;
        else idle_reg <= (probe_supply || full_bus_voltage) ? 16'h0000 : idle_reg + 16'h0001;
    end
    // Transitions of the bit pattern, seen at the sender ahead of the receiver
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) flips_reg <= 16'h0000;
        else if (pattern_en_n) flips_reg <= 16'h0000;
        else flips_reg <= flips_reg + {15'h0000, pattern_bit ^ $past(pattern_bit)};
    end
    sequence s_probe_end;
        $fell(probe_supply) ##1 !full_bus_voltage;
    endsequence
    sequence s_toggle;
        !pattern_en_n && $changed(pattern_bit) ##1 !pattern_en_n;
    endsequence
    probe_on_bound_a: assert property (on_reg <= PROBE_ON)
        else $error("probe held too long");
    probe_repeat_a: assert property (idle_reg <= PROBE_INTERVAL + 2)
        else $error("probe not repeated");
    probe_gap_a: assert property (s_probe_end |-> !probe_supply [*8])
        else $error("probe gap too short");
    swap_clean_a: assert property ($rose(full_bus_voltage) |-> !probe_supply)
        else $error("probe left on with full voltage");
    full_needs_bits_a: assert property ($rose(full_bus_voltage) |-> flips_reg >= 16'h007f)
        else $error("full voltage before pattern seen");
    full_stays_a: assert property ($rose(full_bus_voltage) |=> full_bus_voltage [*8])
        else $error("full voltage dropped");
    pattern_rate_a: assert property (s_toggle |-> $stable(pattern_bit) [*3])
        else $error("pattern bit too short");
    pattern_powered_a: assert property ($fell(pattern_en_n) |-> probe_supply || full_bus_voltage)
        else $error("pattern without bus power");
    pattern_stop_a: assert property ($rose(pattern_en_n) |-> full_bus_voltage || !probe_supply)
        else $error("pattern stopped before full voltage");
endmodule : probe_link_monitor

/* bench/tb_dead_battery_detection.sv */
// Testbench joining both port ends across the probe link
`timescale 1ns/10ps
module tb_dead_battery_detection;
    import probe_link_pkg::*;
    localparam int P_INT = 50;
    localparam int P_ON = 700;
    localparam int FPW = 20;
    logic clk_in, rst_n_in, clk_en_in, detach_in, hard_reset_in, bus_powered_in;
    logic wants_power_in, logic_ready_in, src_a, snk_a, prb_a, src_b, snk_b, prb_b, pav, psnk;
    logic late;
    int err_count = 0;
    int checked = 0;
    int n, k;
    probe_link_if link_a();
    probe_link_if link_b();
    // First end sees no detach: the monitor's probe spacing assumes an undisturbed timer
    cons_prov_port #(.PROBE_INTERVAL(P_INT), .PROBE_ON(P_ON)) i_cons_prov_port (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .detach_in(1'b0),
        .hard_reset_in(hard_reset_in), .bus_powered_in(1'b0), .role_source_out(src_a),
        .role_sink_out(snk_a), .probing_out(prb_a), .link(link_a));
    // Second end faces the bench, which plays a misbehaving partner
    cons_prov_port #(.PROBE_INTERVAL(P_INT), .PROBE_ON(P_ON)) i_cons_prov_port_b (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .detach_in(detach_in),
        .hard_reset_in(hard_reset_in), .bus_powered_in(bus_powered_in), .role_source_out(src_b),
        .role_sink_out(snk_b), .probing_out(prb_b), .link(link_b));
    prov_cons_port #(.FULL_POWER_WAIT(FPW)) i_prov_cons_port (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .wants_power_in(wants_power_in),
        .logic_ready_in(logic_ready_in), .detach_in(1'b0), .power_avail_out(pav),
        .role_sink_out(psnk), .start_late_out(late), .link(link_a));
    probe_link_monitor #(.PROBE_ON(P_ON), .PROBE_INTERVAL(P_INT)) i_probe_link_monitor (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .probe_supply(link_a.probe_supply),
        .full_bus_voltage(link_a.full_bus_voltage), .pattern_bit(link_a.pattern_bit),
        .pattern_en_n(link_a.pattern_en_n));
    task automatic check_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : check_bit
    task automatic step(input int c);
        repeat (c) @(posedge clk_in);
        #1;
    endtask : step
    task automatic send_bits(input int cnt, input int skip);
        for (k = 0; k < cnt; k++) begin
            @(posedge clk_in);
            link_b.pattern_en_n <= 1'b0;
            if (k != skip) link_b.pattern_bit <= ~link_b.pattern_bit;
            repeat (3) @(posedge clk_in);
        end
        @(posedge clk_in);
        link_b.pattern_en_n <= 1'b1;
        link_b.pattern_bit <= ~link_b.pattern_bit;
        #1;
    endtask : send_bits
    task automatic wait_probe_b();
        for (n = 0; n < 800 && link_b.probe_supply === 1'b1; n++) step(1);
        for (n = 0; n < 100 && link_b.probe_supply !== 1'b1; n++) step(1);
    endtask : wait_probe_b
    task automatic test_silent();
        int ra = 0;
        int rb = 0;
        logic pa = 1'b0;
        logic pb = 1'b0;
        logic bad = 1'b0;
        for (n = 0; n < 1700; n++) begin
            step(1);
            ra += int'(link_a.probe_supply && !pa);
            rb += int'(link_b.probe_supply && !pb);
            pa = link_a.probe_supply;
            pb = link_b.probe_supply;
            bad |= link_a.full_bus_voltage | link_b.full_bus_voltage | ~link_a.pattern_en_n;
        end
        check_bit(bad, 1'b0, "full voltage or pattern");
        check_bit(ra >= 2 && rb >= 2, 1'b1, "probes not repeated");
        $display("test silent done");
    endtask : test_silent
    task automatic test_bus_powered();
        logic seen = 1'b0;
        @(posedge clk_in);
        bus_powered_in <= 1'b1;
        step(8);
        check_bit(snk_b, 1'b1, "no sink role");
        for (n = 0; n < 900; n++) begin
            step(1);
            seen |= link_b.probe_supply;
        end
        check_bit(seen, 1'b0, "probe while powered");
        @(posedge clk_in);
        bus_powered_in <= 1'b0;
        detach_in <= 1'b1;
        @(posedge clk_in);
        detach_in <= 1'b0;
        step(3);
        check_bit(snk_b, 1'b0, "sink kept after detach");
        $display("test bus_powered done");
    endtask : test_bus_powered
    task automatic test_broken();
        wait_probe_b();
        send_bits(170, 100);
        check_bit(link_b.full_bus_voltage, 1'b0, "broken pattern accepted");
        wait_probe_b();
        send_bits(150, -1);
        check_bit(link_b.full_bus_voltage, 1'b1, "clean pattern missed");
        $display("test broken done");
    endtask : test_broken
    task automatic test_swap();
        for (n = 0; n < 800 && link_a.probe_supply === 1'b1; n++) step(1);
        // Let the partner's synchronised view of the bus settle first
        step(3);
        @(posedge clk_in);
        wants_power_in <= 1'b1;
        for (n = 0; n < 100 && link_a.probe_supply !== 1'b1; n++) step(1);
        for (n = 0; n < PATTERN_START_CYC && link_a.pattern_en_n !== 1'b0; n++) step(1);
        check_bit(link_a.pattern_en_n, 1'b0, "pattern late");
        check_bit(late, 1'b0, "start limit flagged");
        step(FPW - 3);
        check_bit(pav, 1'b0, "power early");
        step(6);
        check_bit(pav, 1'b1, "power late");
        for (n = FPW + 3; n < 1000 && link_a.full_bus_voltage !== 1'b1; n++) step(1);
        check_bit(link_a.full_bus_voltage, 1'b1, "no full voltage");
        check_bit(n >= 127 * BIT_CYC, 1'b1, "detected too soon");
        step(2);
        check_bit(src_a && !prb_a && !snk_a, 1'b1, "source role");
        @(posedge clk_in);
        logic_ready_in <= 1'b1;
        for (n = 0; n < 20 && link_a.pattern_en_n !== 1'b1; n++) step(1);
        check_bit(link_a.pattern_en_n, 1'b1, "pattern not stopped");
        step(3);
        check_bit(psnk && link_a.full_bus_voltage, 1'b1, "sink role");
        @(posedge clk_in);
        logic_ready_in <= 1'b0;
        hard_reset_in <= 1'b1;
        @(posedge clk_in);
        hard_reset_in <= 1'b0;
        step(3);
        check_bit(src_a | src_b | link_a.full_bus_voltage, 1'b0, "swap kept");
        $display("test swap done");
    endtask : test_swap
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // Tests take about 5000 cycles
    initial begin
        #100000;
        err_count++;
        complete_run();
    end
    initial begin
        rst_n_in = 1'b0;
        clk_en_in = 1'b1;
        {detach_in, hard_reset_in, bus_powered_in, wants_power_in, logic_ready_in} = 5'h00;
        link_b.pattern_bit = 1'b0;
        link_b.pattern_en_n = 1'b1;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        step(1);
        check_bit(link_a.pattern_en_n && !link_a.full_bus_voltage, 1'b1, "reset state");
        test_silent();
        test_bus_powered();
        test_broken();
        test_swap();
        complete_run();
    end
endmodule : tb_dead_battery_detection

/* core/cons_prov_port.sv */
// Consumer/Provider end: probes the bus and takes the source role
`timescale 1ns/10ps
// Summary of operation
// - Stay source role until detach or hard reset
// - Lost connection returns port to default state; the source role ignores it and leaves only on detach or hard reset
// - Probe bus periodically while no full voltage
// - On detection switch probe to full voltage
// - No response means full voltage stays off
// - Keep probing after a silent probe
// - Probe on-time bounded by timer
// - Detection capability always present
// - Partner starts with bus output off
// - Partner sends alternating bit pattern
// - Partner starts pattern within start limit; a later start only sets start_late_out
// - Partner waits full-power interval before logic
// - Partner stops pattern when ready
// - Both record implicit role swap
// - Detect only after 128 alternating bits
// - Interval timer schedules next probe
module cons_prov_port
    import probe_link_pkg::*;
#(
    parameter int PROBE_INTERVAL = PROBE_INTERVAL_CYC,
    parameter int PROBE_ON = PROBE_ON_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic detach_in,
    input wire logic hard_reset_in,
    input wire logic bus_powered_in,
    output logic role_source_out,
    output logic role_sink_out,
    output logic probing_out,
    probe_link_if.cons_prov link
);
    cp_state_t state_reg;
    logic [CNT_W-1:0] timer_reg;
    logic [BITCNT_W-1:0] alt_cnt_reg;
    logic [BITCNT_W-1:0] bit_tmr_reg;
    logic bit_s1_reg, bit_s2_reg, en_s1_reg, en_s2_reg, vbus_s1_reg, vbus_s2_reg;
    // Bit sampler state
    logic last_bit_reg;
    logic have_bit_reg;
    logic listening;
    logic sample_tick;
    logic detected;

    // Partner pins come from the far port's clock: two flip-flops each
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_s1_reg <= 1'b0;
            bit_s2_reg <= 1'b0;
            en_s1_reg <= 1'b1;
            en_s2_reg <= 1'b1;
        end else if (clk_en_in) begin
            bit_s1_reg <= link.pattern_bit;
            bit_s2_reg <= bit_s1_reg;
            en_s1_reg <= link.pattern_en_n;
            en_s2_reg <= en_s1_reg;
        end
    end

    // Bus sense comes from an analog comparator and is synchronised the same way
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vbus_s1_reg <= 1'b0;
            vbus_s2_reg <= 1'b0;
        end else if (clk_en_in) begin
            vbus_s1_reg <= bus_powered_in;
            vbus_s2_reg <= vbus_s1_reg;
        end
    end

    // Bits are sampled once per bit period, and only while the partner
    // enables its pattern during our own probe
    assign listening = (state_reg == CP_PROBE) && !en_s2_reg;
    assign sample_tick = listening && (bit_tmr_reg == BITCNT_W'(BIT_CYC - 1));
    assign detected = (alt_cnt_reg >= BITCNT_W'(PATTERN_DETECT_BITS - 1));

    // Bit period timer; restarts whenever listening stops
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_tmr_reg <= BITCNT_RESET;
        end else if (clk_en_in) begin
            if (!listening || sample_tick) begin
                bit_tmr_reg <= BITCNT_RESET;
            end else begin
                bit_tmr_reg <= bit_tmr_reg + 8'h01;
            end
        end
    end

    // The first sample of a run has nothing to compare with, so a bit left
    // over from an earlier probe can never count as an alternation
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_bit_reg <= 1'b0;
            have_bit_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (!listening) begin
                have_bit_reg <= 1'b0;
            end else if (sample_tick) begin
                last_bit_reg <= bit_s2_reg;
                have_bit_reg <= 1'b1;
            end
        end
    end

    // Consecutive alternations; 127 of them span the 128 bits required
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            alt_cnt_reg <= BITCNT_RESET;
        end else if (clk_en_in) begin
            if (!listening) begin
                alt_cnt_reg <= BITCNT_RESET;
            end else if (sample_tick) begin
                if (have_bit_reg && (bit_s2_reg != last_bit_reg)) begin
                    if (!detected) begin
                        alt_cnt_reg <= alt_cnt_reg + 8'h01;
                    end
                end else begin
                    alt_cnt_reg <= BITCNT_RESET;
                end
            end
        end
    end

    // Port sequencer; one timer serves both the idle interval and the probe
    // on-time, since the two never run together. Detection is always built in.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= CP_IDLE;
            timer_reg <= CNT_RESET;
        end else if (clk_en_in) begin
            if (detach_in || hard_reset_in) begin
                state_reg <= CP_IDLE;
                timer_reg <= CNT_RESET;
            end else begin
                unique case (state_reg)
                    CP_IDLE: begin
                        if (vbus_s2_reg) begin
                            // Partner already sources the bus
                            state_reg <= CP_SINK;
                        end else if (timer_reg >= CNT_W'(PROBE_INTERVAL - 1)) begin
                            state_reg <= CP_PROBE;
                            timer_reg <= CNT_RESET;
                        end else begin
                            timer_reg <= cnt_inc(timer_reg);
                        end
                    end
                    CP_PROBE: begin
                        if (vbus_s2_reg) begin
                            // Partner started sourcing mid-probe; yield at once
                            state_reg <= CP_SINK;
                        end else if (detected) begin
                            state_reg <= CP_SOURCE;
                        end else if (timer_reg >= CNT_W'(PROBE_ON - 1)) begin
                            // Silent probe: back off and retry later
                            state_reg <= CP_IDLE;
                            timer_reg <= CNT_RESET;
                        end else begin
                            timer_reg <= cnt_inc(timer_reg);
                        end
                    end
                    // Held until detach or hard reset; no other loss detection
                    CP_SOURCE: state_reg <= CP_SOURCE;
                    CP_SINK: begin
                        if (!vbus_s2_reg) begin
                            state_reg <= CP_IDLE;
                        end
                    end
                    // Unused codes fall back to idle instead of locking up
                    default: begin
                        state_reg <= CP_IDLE;
                        timer_reg <= CNT_RESET;
                    end
                endcase
            end
        end
    end

    // Bus drive straight from flip-flops; the probe stays on until the edge that
    // applies full voltage, so the partner never sees an unpowered gap
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link.probe_supply <= 1'b0;
            link.full_bus_voltage <= 1'b0;
        end else if (clk_en_in) begin
            link.probe_supply <= (state_reg == CP_PROBE);
            link.full_bus_voltage <= (state_reg == CP_SOURCE);
        end
    end

    // Status outputs straight from flip-flops
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            role_source_out <= 1'b0;
            role_sink_out <= 1'b0;
            probing_out <= 1'b0;
        end else if (clk_en_in) begin
            role_source_out <= (state_reg == CP_SOURCE);
            role_sink_out <= (state_reg == CP_SINK);
            probing_out <= (state_reg == CP_PROBE);
        end
    end
endmodule : cons_prov_port

/* core/probe_link_if.sv */
// Interface joining the two power ports across the cable
`timescale 1ns/10ps
interface probe_link_if;
    logic probe_supply;
    logic full_bus_voltage;
    logic pattern_bit;
    logic pattern_en_n;
    modport cons_prov (output probe_supply, output full_bus_voltage, input pattern_bit,
        input pattern_en_n);
    modport prov_cons (input probe_supply, input full_bus_voltage, output pattern_bit,
        output pattern_en_n);
endinterface : probe_link_if

/* core/probe_link_pkg.sv */
// Shared constants and types for the unpowered-port probe link
package probe_link_pkg;
    // Clock rate and timing figures
    localparam int CLK_MHZ = 200;
    localparam int PROBE_INTERVAL_US = 100;
    localparam int PROBE_ON_US = 20;
    localparam int PATTERN_START_LIMIT_US = 10;
    localparam int FULL_POWER_WAIT_US = 30;
    localparam int PROBE_INTERVAL_CYC = PROBE_INTERVAL_US * CLK_MHZ;
    localparam int PROBE_ON_CYC = PROBE_ON_US * CLK_MHZ;
    localparam int PATTERN_START_CYC = PATTERN_START_LIMIT_US * CLK_MHZ;
    localparam int FULL_POWER_WAIT_CYC = FULL_POWER_WAIT_US * CLK_MHZ;
    // Link bit period in clock cycles and detection threshold
    localparam int BIT_CYC = 4;
    localparam int PATTERN_DETECT_BITS = 128;
    localparam int CNT_W = 16;
    localparam int BITCNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [BITCNT_W-1:0] BITCNT_RESET = 8'h00;

    typedef enum logic [2:0] {
        CP_IDLE = 3'b000,
        CP_PROBE = 3'b001,
        CP_SOURCE = 3'b011,
        CP_SINK = 3'b010
    } cp_state_t;

    typedef enum logic [1:0] {
        PC_OFF = 2'b00,
        PC_PATTERN = 2'b01,
        PC_READY = 2'b11
    } pc_state_t;

    // Saturating counter increment
    function automatic logic [CNT_W-1:0] cnt_inc(input logic [CNT_W-1:0] v);
        cnt_inc = (v == {CNT_W{1'b1}}) ? v : v + 16'h0001;
    endfunction : cnt_inc
endpackage : probe_link_pkg

/* core/prov_cons_port.sv */
// Provider/Consumer end: powers up from the probe and sends the bit pattern
`timescale 1ns/10ps
module prov_cons_port
    import probe_link_pkg::*;
#(
    parameter int FULL_POWER_WAIT = FULL_POWER_WAIT_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic wants_power_in,
    input wire logic logic_ready_in,
    input wire logic detach_in,
    output logic power_avail_out,
    output logic role_sink_out,
    output logic start_late_out,
    probe_link_if.prov_cons link
);
    pc_state_t state_reg;
    logic [CNT_W-1:0] timer_reg;
    logic [BITCNT_W-1:0] bit_tmr_reg;
    logic probe_s1_reg, probe_s2_reg, full_s1_reg, full_s2_reg;
    logic powered;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            probe_s1_reg <= 1'b0;
            probe_s2_reg <= 1'b0;
            full_s1_reg <= 1'b0;
            full_s2_reg <= 1'b0;
        end else if (clk_en_in) begin
            probe_s1_reg <= link.probe_supply;
            probe_s2_reg <= probe_s1_reg;
            full_s1_reg <= link.full_bus_voltage;
            full_s2_reg <= full_s1_reg;
        end
    end

    assign powered = probe_s2_reg || full_s2_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= PC_OFF;
            timer_reg <= CNT_RESET;
            start_late_out <= 1'b0;
        end else if (clk_en_in) begin
            if (detach_in || !powered) begin
                state_reg <= PC_OFF;
                timer_reg <= CNT_RESET;
            end else begin
                unique case (state_reg)
                    PC_OFF: begin
                        if (wants_power_in) begin
                            state_reg <= PC_PATTERN;
                            timer_reg <= CNT_RESET;
                        end else begin
                            timer_reg <= cnt_inc(timer_reg);
                        end
                        // Flag a late start beyond the limit
                        if (timer_reg >= CNT_W'(PATTERN_START_CYC)) begin
                            start_late_out <= 1'b1;
                        end
                    end
                    PC_PATTERN: begin
                        timer_reg <= cnt_inc(timer_reg);
                        if (timer_reg >= CNT_W'(FULL_POWER_WAIT - 1) && logic_ready_in) begin
                            state_reg <= PC_READY;
                        end
                    end
                    PC_READY: state_reg <= PC_READY;
                endcase
            end
        end
    end

    // Alternating pattern toggles once per bit period
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_tmr_reg <= BITCNT_RESET;
            link.pattern_bit <= 1'b0;
            link.pattern_en_n <= 1'b1;
            power_avail_out <= 1'b0;
            role_sink_out <= 1'b0;
        end else if (clk_en_in) begin
            link.pattern_en_n <= (state_reg != PC_PATTERN);
            if (state_reg == PC_PATTERN) begin
                if (bit_tmr_reg == BITCNT_W'(BIT_CYC - 1)) begin
                    bit_tmr_reg <= BITCNT_RESET;
                    link.pattern_bit <= ~link.pattern_bit;
                end else begin
                    bit_tmr_reg <= bit_tmr_reg + 8'h01;
                end
            end else begin
                // Bit holds while disabled; a stop ends the current bit period at once and restarts the bit timer
                bit_tmr_reg <= BITCNT_RESET;
            end
            power_avail_out <= (state_reg != PC_OFF)
                && (timer_reg >= CNT_W'(FULL_POWER_WAIT - 1));
            role_sink_out <= (state_reg == PC_READY);
        end
    end
endmodule : prov_cons_port
